// >>> rtl/vsrau_addr_step.sv
`timescale 1ns/1ps
`default_nettype none
module vsrau_addr_step
   import vsrau_pkg::*;
   (
   input wire logic [31:0] word,
   input wire logic [15:0] addend,
   output logic [31:0] word_nxt,
   output logic end_hit
   );

   logic [15:0] sum;

   // ****************************************
   // wrap in 16 bits, keep limit and stride
   // ****************************************
   assign sum = 16'(word[ADDR_LSB +: 16] + addend);
   assign word_nxt = {word[31:LIMIT_LSB], sum};
   assign end_hit = sum >= {2'b00, word[LIMIT_LSB +: 14]};

endmodule : vsrau_addr_step
`default_nettype wire

// >>> rtl/vsrau_core.sv
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module vsrau_core
   import vsrau_pkg::*;
   #(parameter int ADDR_W = 8)
   (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [4:0] vrf_rd_idx,
   input wire logic [127:0] vrf_rd_data,
   output logic [4:0] rrf_rd_idx,
   input wire logic [31:0] rrf_rd_data,
   output logic ds_req_valid,
   output vsrau_ds_req_type ds_req,
   input wire logic ds_req_ready,
   input wire logic ds_rvalid,
   input wire logic [127:0] ds_rdata,
   output logic vw_valid,
   output logic [4:0] vw_idx,
   output logic [127:0] vw_data,
   output logic [127:0] extra_vector_reg,
   output logic busy
   );

   generate
      if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad
         $error("vsrau_core needs an address width of 5 to 8 bits");
      end
   endgenerate

   typedef struct packed {
      vsrau_fsm_type fsm;
      logic [31:0] ins;
      logic [15:0] post_step_constant;
      logic [4:0] aidx;
      logic [31:0][31:0] areg;
      logic [3:0][15:0] flags;
      vsrau_ds_req_type req;
      logic req_valid;
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic err;
      logic end_last;
      logic [127:0] vx;
      logic vw_valid;
      logic [4:0] vw_idx;
      logic [127:0] vw_data;
   } vsrau_core_state_type;

   vsrau_core_state_type state_r;
   vsrau_core_state_type state_nxt;

   // ****************************************
   // instruction fields
   // ****************************************
   logic [7:0] opc;
   logic [4:0] target_field;
   logic [4:0] first_source_field;
   logic [4:0] step_field;
   logic [2:0] flag_target_select;
   logic [1:0] flag_reg_pick;
   logic [2:0] slct;
   vsrau_kind_type kind;
   logic [4:0] mangled_step_source;
   logic [4:0] cur_aidx;
   logic flag_reg_pick_bit;
   logic imm_step;
   logic [15:0] addend;
   logic [31:0] cur_word;
   logic [31:0] step_word;
   logic end_hit;
   logic [143:0] raw_addr;
   logic [4:0] copy_idx;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic [7:0] waddr;
   logic [7:0] raddr;
   logic [31:0] wmerged;
   logic finish;
   logic [127:0] fin_data;

   assign opc = state_r.ins[OPC_LSB +: 8];
   assign target_field = state_r.ins[TGT_LSB +: 5];
   assign first_source_field = state_r.ins[FIRST_SOURCE_FIELD_LSB +: 5];
   assign step_field = state_r.ins[SRC2_LSB +: 5];
   assign flag_target_select = state_r.ins[FLAG_TARGET_SELECT_LSB +: 3];
   assign flag_reg_pick = state_r.ins[FLAG_REG_PICK_LSB +: 2];
   assign slct = state_r.ins[SLCT_LSB +: 3];
   assign kind = vsrau_decode_kind(opc, state_r.ins[SUB_BIT]);
   assign flag_reg_pick_bit = state_r.flags[flag_reg_pick][slct];
   // the selected flag bit flips the low index bit of the step source
   assign mangled_step_source = {step_field[4:1], step_field[0] ^ flag_reg_pick_bit};
   // stores address through the target field, loads through the first source
   assign cur_aidx = (kind == KIND_RAW_LD || kind == KIND_EXTRA) ? first_source_field
                                                                 : target_field;
   assign cur_word = state_r.areg[cur_aidx];
   assign imm_step = opc == OPC_STA_IH || opc == OPC_STA_IV || opc == OPC_STA_IS;
   assign addend = (kind == KIND_PLAIN || imm_step) ? state_r.post_step_constant
                                                    : state_r.areg[mangled_step_source][15:0];
   assign copy_idx = (target_field & COPY_MASK) |
                     {3'b000, 2'(target_field + state_r.flags[flag_reg_pick][15:FLAG_REG_PICK_SHIFT])};
   assign vrf_rd_idx = (kind == KIND_RAW_LD) ? step_field : first_source_field;
   assign rrf_rd_idx = first_source_field;

   vsrau_addr_step u_step (
      .word(cur_word),
      .addend(addend),
      .word_nxt(step_word),
      .end_hit(end_hit)
   );

   vsrau_raw_addr #(.BANKS(16)) u_raw (
      .base(cur_word[15:0]),
      .vec(vrf_rd_data),
      .use_vec(kind == KIND_RAW_LD),
      .raw_addr(raw_addr)
   );

   function automatic logic [31:0] vsrau_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : vsrau_merge

   // ****************************************
   // bus handshake
   // ****************************************
   assign s_axi_awready = !state_r.aw_got && !state_r.bvalid;
   assign s_axi_wready = !state_r.w_got && !state_r.bvalid;
   assign s_axi_arready = !state_r.rvalid;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign raddr = 8'(s_axi_araddr);

   always_comb begin
      state_nxt = state_r;
      state_nxt.vw_valid = 1'b0;
      waddr = 8'h00;
      wmerged = 32'h0000_0000;
      finish = 1'b0;
      fin_data = ds_rdata;
      // write path: address and data taken in either order
      if (aw_take) begin
         state_nxt.aw_got = 1'b1;
         state_nxt.awaddr = 8'(s_axi_awaddr);
      end
      if (w_take) begin
         state_nxt.w_got = 1'b1;
         state_nxt.wdata = s_axi_wdata;
         state_nxt.wstrb = s_axi_wstrb;
      end
      if (state_r.bvalid && s_axi_bready) begin
         state_nxt.bvalid = 1'b0;
      end
      if (state_nxt.aw_got && state_nxt.w_got) begin
         state_nxt.aw_got = 1'b0;
         state_nxt.w_got = 1'b0;
         state_nxt.bvalid = 1'b1;
         state_nxt.bresp = RESP_OKAY;
         waddr = {state_nxt.awaddr[7:2], 2'b00};
         if (waddr == OFF_INSTR) begin
            wmerged = vsrau_merge(state_r.ins, state_nxt.wdata, state_nxt.wstrb);
         end else if (waddr == OFF_IMM) begin
            wmerged = vsrau_merge({16'h0000, state_r.post_step_constant}, state_nxt.wdata, state_nxt.wstrb);
         end else if (waddr == OFF_ADATA) begin
            wmerged = vsrau_merge(state_r.areg[state_r.aidx], state_nxt.wdata, state_nxt.wstrb);
         end else if (waddr == OFF_FLAG01) begin
            wmerged = vsrau_merge({state_r.flags[1], state_r.flags[0]}, state_nxt.wdata,
                                  state_nxt.wstrb);
         end else if (waddr == OFF_FLAG23) begin
            wmerged = vsrau_merge({state_r.flags[3], state_r.flags[2]}, state_nxt.wdata,
                                  state_nxt.wstrb);
         end else begin
            wmerged = vsrau_merge({27'h0, state_r.aidx}, state_nxt.wdata, state_nxt.wstrb);
         end
         // software may not disturb operands while an operation runs
         if (state_r.fsm != FSM_IDLE) begin
            state_nxt.bresp = RESP_SLVERR;
         end else if (waddr == OFF_INSTR) begin
            state_nxt.ins = wmerged;
            state_nxt.err = 1'b0;
            state_nxt.fsm = FSM_ISSUE;
         end else if (waddr == OFF_IMM) begin
            state_nxt.post_step_constant = wmerged[15:0];
         end else if (waddr == OFF_AIDX) begin
            state_nxt.aidx = wmerged[4:0];
         end else if (waddr == OFF_ADATA) begin
            state_nxt.areg[state_r.aidx] = wmerged;
         end else if (waddr == OFF_FLAG01) begin
            state_nxt.flags[0] = wmerged[15:0];
            state_nxt.flags[1] = wmerged[31:16];
         end else if (waddr == OFF_FLAG23) begin
            state_nxt.flags[2] = wmerged[15:0];
            state_nxt.flags[3] = wmerged[31:16];
         end else begin
            state_nxt.bresp = RESP_SLVERR;
         end
      end
      // read path
      if (state_r.rvalid && s_axi_rready) begin
         state_nxt.rvalid = 1'b0;
      end
      if (ar_take) begin
         state_nxt.rvalid = 1'b1;
         state_nxt.rresp = RESP_OKAY;
         state_nxt.rdata = 32'h0000_0000;
         if ({raddr[7:2], 2'b00} == OFF_INSTR) begin
            state_nxt.rdata = state_r.ins;
         end else if ({raddr[7:2], 2'b00} == OFF_IMM) begin
            state_nxt.rdata = {16'h0000, state_r.post_step_constant};
         end else if ({raddr[7:2], 2'b00} == OFF_STATUS) begin
            state_nxt.rdata = {29'h0, state_r.err, state_r.end_last, state_r.fsm != FSM_IDLE};
         end else if ({raddr[7:2], 2'b00} == OFF_AIDX) begin
            state_nxt.rdata = {27'h0, state_r.aidx};
         end else if ({raddr[7:2], 2'b00} == OFF_ADATA) begin
            state_nxt.rdata = state_r.areg[state_r.aidx];
         end else if ({raddr[7:2], 2'b00} == OFF_FLAG01) begin
            state_nxt.rdata = {state_r.flags[1], state_r.flags[0]};
         end else if ({raddr[7:2], 2'b00} == OFF_FLAG23) begin
            state_nxt.rdata = {state_r.flags[3], state_r.flags[2]};
         end else begin
            state_nxt.rresp = RESP_SLVERR;
         end
      end
      // ****************************************
      // operation sequencer
      // ****************************************
      case (state_r.fsm)
         FSM_IDLE: begin
            state_nxt.req_valid = 1'b0;
         end
         FSM_ISSUE: begin
            state_nxt.req.write = kind == KIND_PLAIN || kind == KIND_STEP ||
                                  kind == KIND_RAW_ST;
            state_nxt.req.mode = vsrau_decode_mode(opc);
            // plain stores OR the offset in, post-step forms use the old address
            state_nxt.req.addr = (kind == KIND_PLAIN) ? (cur_word[15:0] | state_r.post_step_constant)
                                                      : cur_word[15:0];
            state_nxt.req.stride = cur_word[STRIDE_LSB +: 2];
            state_nxt.req.stride_bytes = STRIDE_BASE << cur_word[STRIDE_LSB +: 2];
            state_nxt.req.raw_addr = raw_addr;
            state_nxt.req.wdata = (state_nxt.req.mode == MODE_SCALAR) ?
                                  {96'h0, rrf_rd_data} : vrf_rd_data;
            if (kind == KIND_NONE) begin
               state_nxt.err = 1'b1;
               state_nxt.fsm = FSM_IDLE;
            end else begin
               state_nxt.req_valid = 1'b1;
               state_nxt.fsm = FSM_REQ;
            end
         end
         FSM_REQ: begin
            if (ds_req_ready) begin
               state_nxt.req_valid = 1'b0;
               if (state_r.req.write) begin
                  finish = 1'b1;
               end else begin
                  state_nxt.fsm = FSM_WAIT;
               end
            end
         end
         FSM_WAIT: begin
            finish = ds_rvalid;
         end
         default: begin
            state_nxt.fsm = FSM_IDLE;
         end
      endcase
      if (finish) begin
         state_nxt.fsm = FSM_IDLE;
         if (kind == KIND_STEP || kind == KIND_RAW_ST || kind == KIND_EXTRA) begin
            state_nxt.areg[cur_aidx] = step_word;
         end
         if (flag_target_select < FLAG_TGT_LIMIT &&
             (kind == KIND_PLAIN || kind == KIND_STEP || kind == KIND_EXTRA)) begin
            state_nxt.flags[flag_target_select[1:0]][END_FLAG_BIT] = end_hit;
            state_nxt.end_last = end_hit;
         end
         if (kind == KIND_RAW_LD) begin
            state_nxt.vw_valid = 1'b1;
            state_nxt.vw_idx = target_field;
            state_nxt.vw_data = fin_data;
         end
         if (kind == KIND_EXTRA) begin
            state_nxt.vx = fin_data;
            state_nxt.vw_valid = flag_reg_pick_bit;
            state_nxt.vw_idx = copy_idx;
            state_nxt.vw_data = fin_data;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= '0;
         state_r.fsm <= FSM_IDLE;
         state_r.post_step_constant <= IMM_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign s_axi_bvalid = state_r.bvalid;
   assign s_axi_bresp = state_r.bresp;
   assign s_axi_rvalid = state_r.rvalid;
   assign s_axi_rdata = state_r.rdata;
   assign s_axi_rresp = state_r.rresp;
   assign ds_req_valid = state_r.req_valid;
   assign ds_req = state_r.req;
   assign vw_valid = state_r.vw_valid;
   assign vw_idx = state_r.vw_idx;
   assign vw_data = state_r.vw_data;
   assign extra_vector_reg = state_r.vx;
   assign busy = state_r.fsm != FSM_IDLE;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_req_open;
      state_r.fsm == FSM_REQ && ds_req_valid;
   endsequence
   sequence s_store_taken;
      s_req_open ##0 ds_req_ready && ds_req.write;
   endsequence

   a_plain_or_addr: assert property (s_req_open ##0 kind == KIND_PLAIN |->
      ds_req.write && ds_req.addr == (cur_word[15:0] | state_r.post_step_constant))
      else $error("plain store address is not addr or offset");
   a_step_old_addr: assert property (s_req_open ##0 kind == KIND_STEP |->
      ds_req.addr == cur_word[15:0])
      else $error("step store does not use the old address");
   a_step_writeback: assert property (s_store_taken ##0 kind == KIND_STEP |=>
      state_r.areg[$past(cur_aidx)][15:0] == 16'($past(cur_word[15:0]) + $past(addend)))
      else $error("step store address not advanced");
   a_limit_kept: assert property (s_store_taken ##0 kind != KIND_PLAIN |=>
      state_r.areg[$past(cur_aidx)][31:16] == $past(cur_word[31:16]))
      else $error("post step changed limit or stride");
   a_raw_dir: assert property (s_req_open ##0 kind == KIND_RAW_LD |-> !ds_req.write)
      else $error("raw load issued as a write");
   a_raw_same_cell: assert property (s_req_open ##0 kind == KIND_RAW_ST |->
      ds_req.raw_addr == {16{ds_req.raw_addr[8:0]}})
      else $error("raw store banks differ");
   a_stride_bytes: assert property (ds_req_valid |->
      ds_req.stride_bytes == (8'h10 << ds_req.stride))
      else $error("stride byte count wrong");
   a_end_flag_hold: assert property (s_store_taken ##0 flag_target_select >= 3'h4 |=>
      state_r.flags == $past(state_r.flags, 1) || $past(state_r.bvalid, 1) != 1'b0)
      else $error("end flag written with flag target of four or more");
   a_copy_index: assert property (state_r.fsm == FSM_WAIT && ds_rvalid &&
      kind == KIND_EXTRA && flag_reg_pick_bit |=> vw_valid && vw_idx[4:2] == target_field[4:2])
      else $error("extra copy index wrong");
   a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> s_axi_bvalid)
      else $error("write response missing");

endmodule : vsrau_core
`default_nettype wire

// >>> rtl/vsrau_pkg.sv
// Behaviour
// - opcodes dc/dd/de store 16 horizontal, 16 vertical or 4 scalar bytes at addr|imm.
// - plain store: flag target below 4 sets end flag from (addr+imm)&ffff >= limit.
// - step stores: c4/c5/c6 register step, d5/d6 immediate vertical and scalar.
// - step store writes at old addr, adds step, then updates end flag if flag target below 4.
// - raw load: per bank (addr>>4)|component, bit 0 byte, bits 1-8 cell.
// - opcode d7 with word bit 0 clear is raw load, set is raw store.
// - raw store: same cell and byte in all banks, post-step, no flag output.
// - c8/c9 load extra vector, post-step address, end flag if target below 4.
// - selected flag set: copy into vector (tgt&1c)|((tgt+flag>>4)&3).
// - address register: addr bits 0-15, limit 16-29, stride selector 30-31.
// - stride selector 0..3 means 0x10, 0x20, 0x40, 0x80 bytes.
// - end flag sits at bit 10 of each flag register.
// - horizontal immediate-step store uses opcode d4.
package vsrau_pkg;

   // ****************************************
   // opcodes and instruction word fields
   // ****************************************
   localparam logic [7:0] OPC_ST_H = 8'hdc;
   localparam logic [7:0] OPC_ST_V = 8'hdd;
   localparam logic [7:0] OPC_ST_S = 8'hde;
   localparam logic [7:0] OPC_STA_RH = 8'hc4;
   localparam logic [7:0] OPC_STA_RV = 8'hc5;
   localparam logic [7:0] OPC_STA_RS = 8'hc6;
   localparam logic [7:0] OPC_STA_IH = 8'hd4;
   localparam logic [7:0] OPC_STA_IV = 8'hd5;
   localparam logic [7:0] OPC_STA_IS = 8'hd6;
   localparam logic [7:0] OPC_RAW = 8'hd7;
   localparam logic [7:0] OPC_LDX_H = 8'hc8;
   localparam logic [7:0] OPC_LDX_V = 8'hc9;
   localparam int OPC_LSB = 24;
   localparam int TGT_LSB = 19;
   localparam int FIRST_SOURCE_FIELD_LSB = 14;
   localparam int SRC2_LSB = 9;
   localparam int FLAG_TARGET_SELECT_LSB = 6;
   localparam int FLAG_REG_PICK_LSB = 4;
   localparam int SLCT_LSB = 1;
   localparam int SUB_BIT = 0;

   // ****************************************
   // address and flag register layout
   // ****************************************
   localparam int ADDR_LSB = 0;
   localparam int LIMIT_LSB = 16;
   localparam int STRIDE_LSB = 30;
   localparam int END_FLAG_BIT = 10;
   localparam int FLAG_REG_PICK_SHIFT = 4;
   localparam logic [4:0] COPY_MASK = 5'h1c;
   localparam logic [2:0] FLAG_TGT_LIMIT = 3'h4;
   localparam logic [7:0] STRIDE_BASE = 8'h10;
   localparam int RAW_SHIFT = 4;

   // ****************************************
   // register map and reset values
   // ****************************************
   localparam logic [7:0] OFF_INSTR = 8'h00;
   localparam logic [7:0] OFF_IMM = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_AIDX = 8'h0c;
   localparam logic [7:0] OFF_ADATA = 8'h10;
   localparam logic [7:0] OFF_FLAG01 = 8'h14;
   localparam logic [7:0] OFF_FLAG23 = 8'h18;
   localparam logic [15:0] IMM_RST = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [3:0] {
      FSM_IDLE = 4'b0001,
      FSM_ISSUE = 4'b0010,
      FSM_REQ = 4'b0100,
      FSM_WAIT = 4'b1000
   } vsrau_fsm_type;

   typedef enum logic [2:0] {
      KIND_NONE, KIND_PLAIN, KIND_STEP, KIND_RAW_LD, KIND_RAW_ST, KIND_EXTRA
   } vsrau_kind_type;

   typedef enum logic [1:0] {
      MODE_HORIZ = 2'h0, MODE_VERT = 2'h1, MODE_SCALAR = 2'h2, MODE_RAW = 2'h3
   } vsrau_mode_type;

   typedef struct packed {
      logic write;
      vsrau_mode_type mode;
      logic [15:0] addr;
      logic [1:0] stride;
      logic [7:0] stride_bytes;
      logic [143:0] raw_addr;
      logic [127:0] wdata;
   } vsrau_ds_req_type;

   function automatic vsrau_kind_type vsrau_decode_kind(input logic [7:0] opc,
                                                       input logic sub);
      vsrau_kind_type k;
      k = KIND_NONE;
      if (opc == OPC_ST_H || opc == OPC_ST_V || opc == OPC_ST_S) begin
         k = KIND_PLAIN;
      end else if (opc == OPC_STA_RH || opc == OPC_STA_RV || opc == OPC_STA_RS ||
                   opc == OPC_STA_IH || opc == OPC_STA_IV || opc == OPC_STA_IS) begin
         k = KIND_STEP;
      end else if (opc == OPC_RAW) begin
         k = sub ? KIND_RAW_ST : KIND_RAW_LD;
      end else if (opc == OPC_LDX_H || opc == OPC_LDX_V) begin
         k = KIND_EXTRA;
      end
      return k;
   endfunction : vsrau_decode_kind

   function automatic vsrau_mode_type vsrau_decode_mode(input logic [7:0] opc);
      vsrau_mode_type m;
      m = MODE_RAW;
      if (opc == OPC_ST_H || opc == OPC_STA_RH || opc == OPC_STA_IH || opc == OPC_LDX_H) begin
         m = MODE_HORIZ;
      end else if (opc == OPC_ST_V || opc == OPC_STA_RV || opc == OPC_STA_IV ||
                   opc == OPC_LDX_V) begin
         m = MODE_VERT;
      end else if (opc == OPC_ST_S || opc == OPC_STA_RS || opc == OPC_STA_IS) begin
         m = MODE_SCALAR;
      end
      return m;
   endfunction : vsrau_decode_mode

endpackage : vsrau_pkg

// >>> rtl/vsrau_raw_addr.sv
`timescale 1ns/1ps
`default_nettype none
module vsrau_raw_addr
   import vsrau_pkg::*;
   #(parameter int BANKS = 16)
   (
   input wire logic [15:0] base,
   input wire logic [BANKS*8-1:0] vec,
   input wire logic use_vec,
   output logic [BANKS*9-1:0] raw_addr
   );

   generate
      if (BANKS != 16) begin : g_bad
         $error("vsrau_raw_addr serves exactly 16 banks");
      end
   endgenerate

   logic [11:0] shifted;

   assign shifted = base[15:RAW_SHIFT];

   // ****************************************
   // per-bank cell and byte select
   // ****************************************
   always_comb begin
      raw_addr = '0;
      for (int i = 0; i < BANKS; i++) begin
         // bits 8:1 pick the cell, bit 0 the byte
         raw_addr[i*9 +: 9] = shifted[8:0] | (use_vec ? {1'b0, vec[i*8 +: 8]} : 9'h000);
      end
   end

endmodule : vsrau_raw_addr
`default_nettype wire

// >>> test/vsrau_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module vsrau_core_test;
   import vsrau_pkg::*;
   // ****************************************
   // bench signals, named as the ports
   // ****************************************
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rrf_rd_data;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic ds_req_valid, vw_valid, busy;
   logic ds_req_ready = 1'b1, ds_rvalid = 1'b0;
   logic [4:0] vrf_rd_idx, rrf_rd_idx, vw_idx;
   logic [127:0] vrf_rd_data, ds_rdata = {8{16'h5ac3}}, vw_data, extra_vector_reg;
   logic [132:0] wb = 133'h0;
   logic [31:0] rv;
   vsrau_ds_req_type ds_req, got;
   int mismatches = 0;
   int n_compared = 0;
   // register files answer in the same cycle, each byte tagged with its index
   assign vrf_rd_data = {16{3'h0, vrf_rd_idx}};
   assign rrf_rd_data = {4{3'h0, rrf_rd_idx}};
   always #50 aclk = ~aclk;
   always @(posedge aclk) if (ds_req_valid && ds_req_ready) got <= ds_req;
   always @(posedge aclk) ds_rvalid <= ds_req_valid && ds_req_ready && !ds_req.write;
   always @(posedge aclk) if (vw_valid) wb <= {vw_idx, vw_data};
   vsrau_core u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vrf_rd_idx, .vrf_rd_data, .rrf_rd_idx,
      .rrf_rd_data, .ds_req_valid, .ds_req, .ds_req_ready, .ds_rvalid, .ds_rdata, .vw_valid,
      .vw_idx, .vw_data, .extra_vector_reg, .busy);
   // ****************************************
   // bus and compare tasks
   // ****************************************
   task automatic stop_test(input bit hung);
      if (hung) mismatches++;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (i == 50) stop_test(1'b1);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (i == 50) stop_test(1'b1);
   endtask : rd
   // issue one instruction and wait, bounded, for the unit to go idle
   task automatic run(input logic [7:0] o, input logic [4:0] st, input logic [2:0] cd,
                      input logic sb);
      int i;
      wr(OFF_INSTR, {o, 5'd2, 5'd3, st, cd, 2'h0, 3'h0, sb});
      for (i = 0; i < 50 && busy !== 1'b0; i++) @(posedge aclk);
      if (i == 50) stop_test(1'b1);
      @(posedge aclk);
   endtask : run
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_plain;
      rd(OFF_ADATA);
      chk("areg0 reset", 32'h0, rv);
      wr(OFF_AIDX, 32'h2);
      wr(OFF_ADATA, 32'h4100_00f0);
      wr(OFF_IMM, 32'h10);
      run(OPC_ST_H, 5'd0, 3'd1, 1'b0);
      chk("st addr", 32'h00f0, {16'h0, got.addr});
      chk("st kind", 32'h4, {29'h0, got.write, got.mode});
      chk("st data", 32'h0303_0303, got.wdata[31:0]);
      chk("st stride", 32'h20, {24'h0, got.stride_bytes});
      rd(OFF_FLAG01);
      chk("st flag", 32'h0400_0000, rv);
      $display("plain store done");
   endtask : t_plain
   task automatic t_step;
      wr(OFF_IMM, 32'h20);
      run(OPC_STA_IH, 5'd0, 3'd0, 1'b0);
      chk("stp addr", 32'h00f0, {16'h0, got.addr});
      rd(OFF_ADATA);
      chk("stp areg", 32'h4100_0110, rv);
      rd(OFF_FLAG01);
      chk("stp flag", 32'h0400_0400, rv);
      $display("step store done");
   endtask : t_step
   task automatic t_raw;
      wr(OFF_AIDX, 32'h5);
      wr(OFF_ADATA, 32'h3);
      wr(OFF_AIDX, 32'h2);
      run(OPC_RAW, 5'd5, 3'd2, 1'b1);
      chk("raw kind", 32'h7, {29'h0, got.write, got.mode});
      chk("raw cell", 32'h0011_0011, {7'h0, got.raw_addr[143:135], 7'h0,
          got.raw_addr[8:0]});
      rd(OFF_ADATA);
      chk("raw areg", 32'h4100_0113, rv);
      rd(OFF_FLAG23);
      chk("raw flag", 32'h0, rv);
      rd(8'h40);
      chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      $display("raw store done");
   endtask : t_raw
   task automatic t_extra;
      wr(OFF_FLAG01, 32'h0000_0011);
      run(OPC_LDX_H, 5'd4, 3'd1, 1'b0);
      chk("ldx kind", 32'h0, {29'h0, got.write, got.mode});
      chk("ldx vx", ds_rdata[31:0], extra_vector_reg[31:0]);
      chk("ldx copy", 32'h3, {27'h0, wb[132:128]});
      chk("ldx data", ds_rdata[127:96], wb[127:96]);
      wr(OFF_AIDX, 32'h3);
      rd(OFF_ADATA);
      chk("ldx areg", 32'h3, rv);
      rd(OFF_FLAG01);
      chk("ldx flag", 32'h0400_0011, rv);
      $display("extra load done");
   endtask : t_extra
   task automatic t_rawld;
      run(OPC_RAW, 5'd6, 3'd0, 1'b0);
      chk("rdl kind", 32'h3, {29'h0, got.write, got.mode});
      chk("rdl cell", 32'h0006_0006, {7'h0, got.raw_addr[143:135], 7'h0,
          got.raw_addr[8:0]});
      chk("rdl dest", 32'h2, {27'h0, wb[132:128]});
      $display("raw load done");
   endtask : t_rawld
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_plain();
      t_step();
      t_raw();
      t_extra();
      t_rawld();
      stop_test(1'b0);
   end
endmodule : vsrau_core_test
`default_nettype wire
